/* File: core/adr_pkg.sv */
/*
 Package for the diagnostic redundancy checker: command codes, mode table,
 timing counts, fault word layout and the host's own register map.
 Assumes a 250 MHz reference clock shared by both ends.
*/
package adr_pkg;
   // ==========================================================
   // Clock and timing
   localparam int unsigned CLK_MHZ = 250;
   // Whole four-parameter run, fastest and slowest mode, in us
   localparam int unsigned T_FAST_US = 742;
   localparam int unsigned T_SLOW_US = 134211;
   // Cycles per us at the clock rate
   localparam int unsigned CYC_PER_US = CLK_MHZ;
   // ==========================================================
   // Commands
   typedef enum logic [3:0] {
      ADR_CMD_NONE,
      ADR_CMD_CELL,
      ADR_CMD_OPEN_WIRE,
      ADR_CMD_CELL_ST,
      ADR_CMD_OVERLAP,
      ADR_CMD_AUX,
      ADR_CMD_AUX_RED,
      ADR_CMD_AUX_OW,
      ADR_CMD_AUX_ST,
      ADR_CMD_STAT,
      ADR_CMD_STAT_RED,
      ADR_CMD_STAT_ST,
      ADR_CMD_CELL_GPIO,
      ADR_CMD_CELL_SUM
   } adr_cmd_type;
   // ==========================================================
   // Fault word: upper byte all ones, nibble flags in low bits
   localparam logic [11:0] FAULT_HEAD = 12'hff0;
   // Number of measured internal quantities
   localparam int unsigned N_PARAM = 4;
   // Number of conversion-rate modes
   localparam int unsigned N_MODE = 8;
   // ==========================================================
   // Host register map (APB byte addresses)
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_SUM_TEMP = 8'h08;
   localparam logic [7:0] OFS_ASUP_DSUP = 8'h0c;
   // Control fields
   localparam int unsigned CTRL_GO_BIT = 0;
   localparam int unsigned CTRL_RED_BIT = 1;
   localparam int unsigned CTRL_MODE_LSB = 4;
   localparam int unsigned CTRL_PS_LSB = 8;
   localparam int unsigned CTRL_PS_EN_BIT = 10;
   localparam int unsigned CTRL_FORCE_BIT = 11;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // Run length in cycles of one quantity for a mode (one quarter of total)
   function automatic logic [31:0] adr_param_cycles(input logic [2:0] mode,
                                                    input logic [31:0] fast,
                                                    input logic [31:0] slow);
      logic [31:0] tot;
      // Linear from fastest (mode 0) to slowest (last mode) total time
      tot = fast + (((slow - fast) * {29'd0, mode}) / (N_MODE - 32'd1));
      return tot / N_PARAM;
   endfunction : adr_param_cycles
endpackage : adr_pkg

/* File: core/adr_link_if.sv */
/*
 Link between host controller and device: command strobe with options,
 result strobe with word and index. Both ends share one clock.
*/
`timescale 1ns/1ps
interface adr_link_if;
   import adr_pkg::*;
   logic cmd_valid; // One-cycle command strobe
   adr_cmd_type cmd; // Command code
   logic [2:0] mode; // Conversion-rate mode
   logic [1:0] path_sel; // redundancy_path_select
   logic path_sel_en; // Host override of automatic choice
   logic force_fail; // force_redundancy_fail
   logic busy; // Device converting
   logic res_valid; // One-cycle result strobe
   logic [1:0] res_idx; // 0 sum,1 temp,2 analog,3 digital
   logic [15:0] res_data; // Result word
   logic done; // One-cycle end of command
   modport host (output cmd_valid, cmd, mode, path_sel, path_sel_en, force_fail,
                 input busy, res_valid, res_idx, res_data, done);
   modport dev (input cmd_valid, cmd, mode, path_sel, path_sel_en, force_fail,
                output busy, res_valid, res_idx, res_data, done);
endinterface : adr_link_if

/* File: core/adr_device.sv */
/*
 Device end: sequences the internal-parameter measurement, runs the
 primary and redundant digital machines and stores results in status
 groups A and B. Modulator bit streams of the three paths are inputs.
 Latches the host's options at command start; the host may change them later.
*/
// Notes on behaviour
// - Internal command converts four internal quantities
// - All eight conversion modes accepted
// - Run takes 742 to 134211 us
// - Stack sum code kept in group A
// - Host scales stack sum by thirty
// - Die temperature code kept in group A
// - Analog in group A, digital in B
// - Redundant variant adds check, same time
// - Host keeps path select 0/1 for redundancy
// - Three primary machines plus one shared redundant
// - Redundancy on all but two plain commands
// - Selected stream feeds both machines, compared
// - Mismatch writes fault word instead
// - Fault nibble flags mark mismatched nibbles
// - Host treats 6.528 V up as fault
// - One path checked, chosen automatically default
// - Host path select overrides automatic choice
// - Force bit makes every check fail
// - Plain variants identical bar redundancy check
`timescale 1ns/1ps
module adr_device
   import adr_pkg::*;
#(
   parameter int unsigned FAST_US = T_FAST_US, // Fastest total time
   parameter int unsigned SLOW_US = T_SLOW_US  // Slowest total time
) (
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   adr_link_if.dev link,
   input wire logic [2:0] mod_bit_i, // Modulator streams of ADC1..3 (pins)
   input wire logic red_glitch_i, // Test hook: corrupts redundant machine
   output logic [15:0] stat_a_sum_o, // Group A stack sum
   output logic [15:0] stat_a_temp_o, // Group A die temperature
   output logic [15:0] stat_a_asup_o, // Group A analog supply
   output logic [15:0] stat_b_dsup_o // Group B digital supply
);
   // Times must be ordered and the mode scaling must fit 32 bits
   if (SLOW_US < FAST_US ||
       64'(SLOW_US) * CYC_PER_US * (N_MODE - 1) > 64'hffff_ffff) begin : g_bad_times
      $error("adr_device: run times out of range");
   end
   // ==========================================================
   // Input synchronisers
   logic [2:0] mod_s1_reg, mod_s2_reg;
   // Two stages before any machine reads the streams
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mod_s1_reg <= 3'h0;
         mod_s2_reg <= 3'h0;
      end else begin
         mod_s1_reg <= mod_bit_i;
         mod_s2_reg <= mod_s1_reg;
      end
   end
   // ==========================================================
   // Sequencer
   typedef enum logic [1:0] {ADR_IDLE, ADR_CONV, ADR_STORE} adr_state_type;
   adr_state_type state_reg;
   logic [31:0] cnt_reg; // Cycles left in current quantity
   logic [31:0] len_reg; // Cycles per quantity for this mode
   logic [1:0] idx_reg; // Quantity being converted
   logic red_reg; // Redundant variant running
   logic [1:0] prim_path_reg; // ADC feeding the primary result
   logic chk_reg; // Redundancy really applied
   logic force_reg; // Latched force-fail
   logic [15:0] prim_acc_reg [3]; // Primary machine per ADC
   logic [15:0] red_acc_reg; // Shared redundant machine
   logic [15:0] prim_res, diff_res;
   logic [3:0] nib_flag;
   logic [15:0] final_res;
   logic start;
   assign start = link.cmd_valid && state_reg == ADR_IDLE &&
                  (link.cmd == ADR_CMD_STAT || link.cmd == ADR_CMD_STAT_RED);

   // Compare nibbles of primary and redundant results
   always_comb begin
      prim_res = prim_acc_reg[prim_path_reg];
      diff_res = prim_res ^ red_acc_reg;
      for (int n = 0; n < 4; n++) begin
         nib_flag[n] = (|diff_res[n*4 +: 4]) | force_reg;
      end
      if (chk_reg && (nib_flag != 4'h0)) begin
         final_res = {FAULT_HEAD, nib_flag};
      end else begin
         final_res = prim_res;
      end
   end

   // Command latch and sequencing
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_reg <= ADR_IDLE;
         cnt_reg <= 32'h0;
         len_reg <= 32'h0;
         idx_reg <= 2'h0;
         red_reg <= 1'b0;
         prim_path_reg <= 2'h0;
         chk_reg <= 1'b0;
         force_reg <= 1'b0;
      end else begin
         case (state_reg)
            ADR_IDLE: begin
               if (start) begin
                  // per-mode length, same for both variants
                  len_reg <= adr_param_cycles(link.mode, FAST_US * CYC_PER_US,
                                              SLOW_US * CYC_PER_US);
                  cnt_reg <= adr_param_cycles(link.mode, FAST_US * CYC_PER_US,
                                              SLOW_US * CYC_PER_US);
                  idx_reg <= 2'h0;
                  red_reg <= (link.cmd == ADR_CMD_STAT_RED);
                  // automatic ADC1 unless override selects 2/3
                  if (link.path_sel_en && link.path_sel[1]) begin
                     prim_path_reg <= link.path_sel[0] ? 2'd2 : 2'd1;
                     chk_reg <= 1'b0;
                  end else begin
                     prim_path_reg <= 2'd0;
                     chk_reg <= (link.cmd == ADR_CMD_STAT_RED);
                  end
                  force_reg <= link.force_fail;
                  state_reg <= ADR_CONV;
               end
            end
            ADR_CONV: begin
               if (cnt_reg <= 32'h1) begin
                  state_reg <= ADR_STORE;
               end else begin
                  cnt_reg <= cnt_reg - 32'h1;
               end
            end
            default: begin
               if (idx_reg == 2'd3) begin
                  state_reg <= ADR_IDLE;
               end else begin
                  idx_reg <= idx_reg + 2'h1;
                  cnt_reg <= len_reg;
                  state_reg <= ADR_CONV;
               end
            end
         endcase
      end
   end

   // integration machines; stream of selected path also feeds redundant
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (int a = 0; a < 3; a++) prim_acc_reg[a] <= 16'h0;
         red_acc_reg <= 16'h0;
      end else if (start || state_reg == ADR_STORE) begin
         for (int a = 0; a < 3; a++) prim_acc_reg[a] <= 16'h0;
         red_acc_reg <= 16'h0;
      end else if (state_reg == ADR_CONV) begin
         for (int a = 0; a < 3; a++) begin
            prim_acc_reg[a] <= prim_acc_reg[a] + {15'h0, mod_s2_reg[a]};
         end
         // Redundant machine idles in plain runs to save toggling
         if (red_reg) begin
            red_acc_reg <= red_acc_reg + {15'h0, mod_s2_reg[prim_path_reg]} +
                           {15'h0, red_glitch_i};
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         stat_a_sum_o <= 16'h0;
         stat_a_temp_o <= 16'h0;
         stat_a_asup_o <= 16'h0;
         stat_b_dsup_o <= 16'h0;
      end else if (state_reg == ADR_STORE) begin
         case (idx_reg)
            2'd0: stat_a_sum_o <= final_res;
            2'd1: stat_a_temp_o <= final_res;
            2'd2: stat_a_asup_o <= final_res;
            default: stat_b_dsup_o <= final_res;
         endcase
      end
   end

   // Link outputs, all registered
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         link.busy <= 1'b0;
         link.res_valid <= 1'b0;
         link.res_idx <= 2'h0;
         link.res_data <= 16'h0;
         link.done <= 1'b0;
      end else begin
         // Busy covers the done cycle so no result shows while idle
         link.busy <= start || (state_reg != ADR_IDLE);
         link.res_valid <= (state_reg == ADR_STORE);
         link.done <= (state_reg == ADR_STORE && idx_reg == 2'd3);
         if (state_reg == ADR_STORE) begin
            link.res_idx <= idx_reg;
            link.res_data <= final_res;
         end
      end
   end
endmodule : adr_device

/* File: core/adr_host.sv */
/*
 Host end: APB slave with control, status and result registers; issues
 commands on the link and collects the four results.
 Assumes a single APB master on the same clock.
*/
`timescale 1ns/1ps
module adr_host
   import adr_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   adr_link_if.host link,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o
);
   // ==========================================================
   // Registers
   logic [31:0] ctrl_reg; // Mode, select, force bits
   logic [15:0] res_reg [4]; // Collected results
   logic busy_reg, done_reg;
   logic wr, rd;
   assign wr = psel_i && penable_i && pwrite_i;
   assign rd = psel_i && !penable_i && !pwrite_i;

   // Control register and command strobe; host sets select
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ctrl_reg <= CTRL_RESET;
         link.cmd_valid <= 1'b0;
         link.cmd <= ADR_CMD_NONE;
         link.mode <= 3'h0;
         link.path_sel <= 2'h0;
         link.path_sel_en <= 1'b0;
         link.force_fail <= 1'b0;
      end else begin
         link.cmd_valid <= 1'b0;
         if (wr && paddr_i == OFS_CTRL) begin
            ctrl_reg <= pwdata_i & ~(32'h1 << CTRL_GO_BIT);
            link.mode <= pwdata_i[CTRL_MODE_LSB +: 3];
            link.path_sel <= pwdata_i[CTRL_PS_LSB +: 2];
            link.path_sel_en <= pwdata_i[CTRL_PS_EN_BIT];
            link.force_fail <= pwdata_i[CTRL_FORCE_BIT];
            if (pwdata_i[CTRL_GO_BIT] && !link.busy) begin
               link.cmd_valid <= 1'b1;
               link.cmd <= pwdata_i[CTRL_RED_BIT] ? ADR_CMD_STAT_RED : ADR_CMD_STAT;
            end
         end
      end
   end

   // Status and results; done set wins over clear-on-read
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < 4; i++) res_reg[i] <= 16'h0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         busy_reg <= link.busy;
         if (link.res_valid) res_reg[link.res_idx] <= link.res_data;
         if (link.done) begin
            done_reg <= 1'b1;
         end else if (psel_i && penable_i && !pwrite_i && paddr_i == OFS_STAT) begin
            done_reg <= 1'b0;
         end
      end
   end

   // APB answer: setup decodes, access completes in one cycle
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         prdata_o <= 32'h0;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         pready_o <= psel_i && !penable_i;
         pslverr_o <= 1'b0;
         if (psel_i && !penable_i) begin
            if (paddr_i == OFS_CTRL) begin
               prdata_o <= rd ? ctrl_reg : 32'h0;
            end else if (paddr_i == OFS_STAT) begin
               prdata_o <= rd ? {30'h0, done_reg, busy_reg} : 32'h0;
            end else if (paddr_i == OFS_SUM_TEMP) begin
               prdata_o <= rd ? {res_reg[1], res_reg[0]} : 32'h0;
            end else if (paddr_i == OFS_ASUP_DSUP) begin
               prdata_o <= rd ? {res_reg[3], res_reg[2]} : 32'h0;
            end else begin
               prdata_o <= 32'h0;
               pslverr_o <= 1'b1;
            end
         end
      end
   end
endmodule : adr_host

/* File: tb/adr_link_chk_sva.sv */
/*
 Checker on the link between host and device end: command start, result
 order and spacing, run length and fault-word form.
 Assumes one clock for both ends and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module adr_link_chk
   import adr_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic reset_n_i,
   input wire logic cmd_valid,
   input wire adr_cmd_type cmd,
   input wire logic [1:0] path_sel,
   input wire logic path_sel_en,
   input wire logic force_fail,
   input wire logic busy,
   input wire logic res_valid,
   input wire logic [1:0] res_idx,
   input wire logic [15:0] res_data,
   input wire logic done
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   // ====================================
   // Helper state
   logic take; // Internal command accepted
   logic red_reg; // Redundant check applies to this run
   logic frc_reg; // Forced failure applies to this run
   logic [1:0] idx_reg; // Index expected for next result
   assign take = cmd_valid && !busy && (cmd == ADR_CMD_STAT || cmd == ADR_CMD_STAT_RED);
   // Latch options at command start; the host may change them later
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         red_reg <= 1'b0;
         frc_reg <= 1'b0;
      end else if (take) begin
         // Auto path and select 0/1 both use the checked path
         red_reg <= (cmd == ADR_CMD_STAT_RED) && !(path_sel_en && path_sel[1]);
         frc_reg <= force_fail && (cmd == ADR_CMD_STAT_RED) && !(path_sel_en && path_sel[1]);
      end
   end
   // Count results within one run
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         idx_reg <= 2'd0;
      end else if (take) begin
         idx_reg <= 2'd0;
      end else if (res_valid) begin
         idx_reg <= idx_reg + 2'd1;
      end
   end
   // ====================================
   // Assertions
   AST_BUSY_ON_CMD: assert property (take |=> busy)
      else $error("busy did not follow the command");
   AST_RES_ORDER: assert property (res_valid |-> res_idx == idx_reg)
      else $error("result index out of order");
   AST_DONE_LAST: assert property (done |-> res_valid && res_idx == 2'd3)
      else $error("done not with the fourth result");
   AST_DONE_ENDS: assert property (done |=> !busy && !done)
      else $error("busy or done stayed after end");
   AST_BUSY_HOLDS: assert property (busy && !done |=> busy)
      else $error("busy dropped before done");
   AST_IDLE_QUIET: assert property (!busy |-> !res_valid && !done)
      else $error("result outside a run");
   AST_RES_GAP: assert property (res_valid && !done |=> !res_valid [*2])
      else $error("results too close together");
   AST_RUN_BOUND: assert property ($rose(busy) |-> ##[8:1000] done)
      else $error("run did not end in time");
   AST_FORCED: assert property (res_valid && frc_reg |-> res_data[15:4] == FAULT_HEAD)
      else $error("forced failure not reported");
   AST_NIBBLE: assert property (res_valid && red_reg && res_data[15:4] == FAULT_HEAD
      |-> res_data[3:0] != 4'h0)
      else $error("fault word without nibble flag");
   AST_PLAIN: assert property (res_valid && !red_reg |-> res_data[15:4] != FAULT_HEAD)
      else $error("fault word from an unchecked run");
   // ====================================
   // Coverage of main cases
   COV_RUN: cover property ($rose(busy));
   COV_RED_DONE: cover property (done && red_reg);
   COV_FAULT: cover property (res_valid && res_data[15:4] == FAULT_HEAD);
endmodule : adr_link_chk

/* File: tb/adc_diag_redundancy_checker_tb.sv */
/*
 Testbench: host and device ends joined by the link; APB drives commands.
 Assumes shortened run times through the device parameters.
*/
`timescale 1ns/1ps
module adc_diag_redundancy_checker_tb;
   import adr_pkg::*;
   localparam int T0 = 1 * CYC_PER_US; // Expected fastest run in cycles
   localparam int T7 = 2 * CYC_PER_US; // Expected slowest run in cycles
   localparam int L0 = T0 / N_PARAM; // Cycles per quantity in mode 0
   typedef struct packed {logic [1:0] kind; logic [1:0] idx; logic [15:0] val;} adr_note_type;
   logic ref_clk_i = 1'b0;
   logic reset_n_i, psel, penable, pwrite, pready, pslverr, glitch;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [2:0] mod_bit; // Modulator streams, random constant levels
   logic [15:0] sum, temp, asup, dsup;
   logic [15:0] got [4]; // Last results seen per index
   logic [15:0] ref_res [4]; // Expected primary results, from the ADC1 stream level
   adr_note_type notes[$]; // Expected results, oldest first
   adr_note_type nt;
   int fail_count = 0;
   int checks = 0;
   adr_link_if link();
   adr_host u_adr_host (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .link(link),
      .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));
   adr_device #(.FAST_US(1), .SLOW_US(2)) u_adr_device (.ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i), .link(link), .mod_bit_i(mod_bit), .red_glitch_i(glitch),
      .stat_a_sum_o(sum), .stat_a_temp_o(temp), .stat_a_asup_o(asup), .stat_b_dsup_o(dsup));
   adr_link_chk u_adr_link_chk (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
      .cmd_valid(link.cmd_valid), .cmd(link.cmd), .path_sel(link.path_sel),
      .path_sel_en(link.path_sel_en), .force_fail(link.force_fail), .busy(link.busy),
      .res_valid(link.res_valid), .res_idx(link.res_idx), .res_data(link.res_data),
      .done(link.done));
   // 250 MHz clock
   always #2 ref_clk_i = ~ref_clk_i;
   // ====================================
   // Comparison and closing
   task automatic chk(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask : chk
   task automatic end_sim();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_sim
   // APB transfer; waits for pready without a bound, then checks that the wait took under 50 cycles
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic err);
      int n;
      n = 0;
      @(posedge ref_clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk_i);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk_i);
         n++;
      end while (pready !== 1'b1);
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk(n < 50, "no pready");
   endtask : apb
   // One internal run: note expectations, start it, wait for done, check groups
   task automatic run(input logic red, input logic [2:0] md, input logic [2:0] ps,
                      input logic frc, input logic gl, input logic [1:0] kind, output int dur);
      logic [31:0] r;
      logic e;
      logic [15:0] pv, rv; // Expected primary and redundant results
      logic [3:0] fl; // Expected nibble flags
      glitch <= gl;
      // expected flags; glitch adds one per conversion cycle
      for (int i = 0; i < 4; i++) begin
         pv = ref_res[i];
         rv = pv + (gl ? 16'(L0) : 16'h0);
         for (int n = 0; n < 4; n++) fl[n] = frc | (|(pv[n*4 +: 4] ^ rv[n*4 +: 4]));
         notes.push_back('{kind, i[1:0], (kind == 2'd1) ? {FAULT_HEAD, fl} : pv});
      end
      apb(1'b1, OFS_CTRL, {20'h0, frc, ps, 1'b0, md, 2'b0, red, 1'b1}, r, e);
      dur = 0;
      while (link.done !== 1'b1 && dur < 2000) begin
         @(posedge ref_clk_i);
         dur++;
      end
      chk(dur < 2000, "run never ended");
      @(posedge ref_clk_i);
      chk(sum === got[0] && temp === got[1] && asup === got[2], "group A");
      chk(dsup === got[3] && notes.size() == 0, "group B or missing result");
      apb(1'b0, OFS_SUM_TEMP, 32'h0, r, e);
      chk(r === {got[1], got[0]}, "sum and temp word");
      apb(1'b0, OFS_ASUP_DSUP, 32'h0, r, e);
      chk(r === {got[3], got[2]}, "supply word");
      $display("test red=%0b mode=%0d ps=%0d frc=%0b done", red, md, ps, frc);
   endtask : run
   // ====================================
   // Result monitor: each result takes the oldest note
   always @(posedge ref_clk_i) begin
      if (link.res_valid === 1'b1) begin
         chk(notes.size() != 0, "unexpected result");
         if (notes.size() != 0) begin
            nt = notes.pop_front();
            got[link.res_idx] = link.res_data;
            chk(link.res_idx === nt.idx, "result order");
            if (nt.kind == 2'd0) chk(link.res_data[15:4] !== FAULT_HEAD, "fault word");
            else if (nt.kind == 2'd1) chk(link.res_data === nt.val
               && link.res_data >= 16'hff00, "wrong fault word");
            else chk(link.res_data === nt.val, "checked result changed");
         end
      end
   end
   // ====================================
   // Main sequence
   initial begin
      logic [31:0] r;
      logic e;
      int d0, d1, dp;
      reset_n_i = 1'b0;
      {psel, penable, pwrite, glitch} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      r = $urandom(32'h5aeb0d3d);
      mod_bit = 3'($urandom);
      ref_res = '{16'h0, 16'h0, 16'h0, 16'h0};
      repeat (4) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      apb(1'b0, OFS_CTRL, 32'h0, r, e);
      chk(r === CTRL_RESET && e === 1'b0, "control reset value");
      apb(1'b0, 8'h10, 32'h0, r, e);
      chk(e === 1'b1 && r === 32'h0, "unmapped access");
      $display("test registers done");
      // Plain run ignores a corrupted redundant machine
      run(1'b0, 3'd0, 3'd0, 1'b0, 1'b1, 2'd0, d0);
      apb(1'b0, OFS_STAT, 32'h0, r, e);
      chk(r[1] === 1'b1 && r[0] === 1'b0, "done flag or busy");
      apb(1'b0, OFS_STAT, 32'h0, r, e);
      chk(r[1] === 1'b0, "done flag not cleared");
      // ADC1 stream level counted over one quantity's run length
      ref_res = '{4{mod_bit[0] ? 16'(L0) : 16'h0}};
      run(1'b1, 3'd0, 3'd0, 1'b0, 1'b0, 2'd2, d1);
      chk(d1 == d0, "redundant run time differs");
      run(1'b1, 3'd0, 3'd0, 1'b0, 1'b1, 2'd1, dp);
      for (int p = 0; p < 4; p++) run(1'b1, 3'd0, {1'b1, p[1:0]}, 1'b0, 1'b1,
         (p < 2) ? 2'd1 : 2'd0, dp);
      run(1'b1, 3'd0, 3'd0, 1'b1, 1'b0, 2'd1, dp);
      d1 = 0;
      for (int m = 0; m < 8; m++) begin
         mod_bit <= 3'($urandom);
         run(1'b0, m[2:0], 3'd0, 1'b0, 1'($urandom), 2'd0, dp);
         chk(dp >= d1, "slower mode ran faster");
         if (m == 0) chk(dp > T0 - T0 / 32 - 8 && dp < T0 + T0 / 32 + 8, "fast time");
         if (m == 7) chk(dp > T7 - T7 / 32 - 8 && dp < T7 + T7 / 32 + 8, "slow time");
         d1 = dp;
      end
      end_sim();
   end
   // Watchdog well beyond the expected run length
   initial begin
      repeat (30000) @(posedge ref_clk_i);
      fail_count++;
      end_sim();
   end
endmodule : adc_diag_redundancy_checker_tb
